// [lss_regs.svh]
/*
  Constants of the load step sequencer: timing, limits and reset values.
  Assumes a 20 MHz instrument clock; included by bare name.
*/
`ifndef LSS_REGS_SVH
`define LSS_REGS_SVH

`define LSS_CLK_NS 50
// Time base resolution, 0.025 ms
`define LSS_TICK_NS 25000
`define LSS_TICK_CYC ((`LSS_TICK_NS + `LSS_CLK_NS - 1) / `LSS_CLK_NS)
`define LSS_MAX_STEPS 1000
`define LSS_MIN_FAST_STEPS 3
`define LSS_MAX_LOOPS 9999
// Time base range in ticks: 0.025 ms to 600 ms
`define LSS_TB_MIN 1
`define LSS_TB_MAX 24000
`define LSS_MEMO_CHARS 12
`define LSS_THRESH_HOURS 1000
`define LSS_NS_PER_HOUR 64'd3600000000000
`define LSS_THRESH_TICKS (64'(`LSS_THRESH_HOURS) * `LSS_NS_PER_HOUR / 64'(`LSS_TICK_NS))
`define LSS_SETPOINT_RST 16'h0000

`endif

// [lss_pkg.sv]
/*
  Types of the load step sequencer: modes, ranges, states, config and status.
  Assumes lss_regs.svh is compiled with it.
*/
package lss_pkg;

  typedef enum logic [1:0] {
    const_current_mode,
    const_resistance_mode,
    const_voltage_mode,
    const_power_mode
  } lss_mode_e;

  typedef enum logic [2:0] {
    low_i_low_v_range,
    mid_i_low_v_range,
    high_i_low_v_range,
    low_i_high_v_range,
    mid_i_high_v_range,
    high_i_high_v_range
  } lss_range_e;

  typedef enum logic [1:0] {
    LSS_IDLE,
    LSS_RUN,
    LSS_PAUSED,
    LSS_HOLD
  } lss_state_e;

  typedef struct packed {
    logic fast;
    lss_mode_e mode;
    lss_range_e range;
    logic [13:0] loops;
    logic loop_inf;
    logic end_hold;
    logic [15:0] hold_level;
    logic [10:0] loop_end_step;
    logic [14:0] time_base;
    logic [3:0] seq_index;
  } lss_cfg_s;

  typedef struct packed {
    logic [3:0] seq_index;
    logic [10:0] step_index;
    logic [13:0] loop_count;
    logic [14:0] step_time;
    logic [39:0] run_time;
    logic run_time_is_elapsed;
    logic running;
    logic paused;
    logic no_seq;
    logic complete;
    logic rejected;
  } lss_stat_s;

endpackage : lss_pkg

// [lss_step_mem.sv]
/*
  Setpoint step store: one write port, one read port with registered data.
  Assumes the writer keeps the address below DEPTH.
*/
`timescale 1ns/10ps
`default_nettype none

module lss_step_mem #(
  parameter int unsigned DEPTH = 1000,
  parameter int unsigned AW = 10,
  parameter int unsigned DW = 16
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [DEPTH];

  // No reset on the array; read data is valid one edge after the address
  always_ff @(posedge ref_clk) begin
    if (wr_en && (32'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : lss_step_mem

`default_nettype wire

// [lss_sequencer.sv]
/*
  Load step sequencer: runs normal and fast setpoint sequences from panel commands.
  Assumes panel commands are one-cycle pulses from logic on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lss_regs.svh"

// How it works
// RULE1 - Load-on with sequence mode enabled starts the sequence immediately.
// RULE2 - Load-off while running turns the load off and ends the sequence.
// RULE3 - Pause freezes progress; continue resumes from the same point.
// RULE4 - Run with no steps defined is refused and flags no-sequence.
// RULE5 - Finishing the last step of the last loop flags completion.
// RULE6 - Running status shows sequence, step, loop and step time.
// RULE7 - Run time shows elapsed beyond 1000 hours, remaining otherwise; the code also shows elapsed for any infinite-loop run.
// RULE8 - Every fast step lasts exactly one common time base.
// RULE9 - Fast runs accepted only in constant current or resistance mode.
// RULE10 - Step store holds at most 1000 setpoints.
// RULE11 - Loop count is 1 to 9999 or infinite until stopped.
// RULE12 - With end-hold on, the hold level is driven after the end.
// RULE13 - Setpoint changes abruptly at each step boundary, never ramped.
// RULE14 - Each fast sequence keeps a 12 character memo; the code keeps one memo shared by all sequences.
// RULE15 - Fast range is low, middle or high current with low voltage.
// RULE16 - Time base 0.025 to 600 ms sets every step period.
// RULE17 - Loop end step ends each loop, then back to step one.
// RULE18 - A fast sequence needs at least 3 steps to run.
// RULE19 - A tick counter reloads with the time base at each boundary.
// RULE20 - Pause stops step timer and run-time counters alike.
module lss_sequencer import lss_pkg::*; #(
  parameter int unsigned DEPTH = `LSS_MAX_STEPS,
  parameter int unsigned TICK_CYC = `LSS_TICK_CYC,
  parameter logic [39:0] THRESH_TICKS = 40'(`LSS_THRESH_TICKS)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic seq_enable,
  input wire logic load_on_cmd,
  input wire logic load_off_cmd,
  input wire logic pause_cmd,
  input wire logic continue_cmd,
  input wire lss_cfg_s cfg,
  input wire logic [10:0] step_count,
  input wire logic step_wr_en,
  input wire logic [9:0] step_wr_addr,
  input wire logic [15:0] step_wr_data,
  input wire logic memo_wr_en,
  input wire logic [3:0] memo_wr_idx,
  input wire logic [7:0] memo_wr_char,
  output lss_stat_s stat,
  output logic [15:0] setpoint,
  output logic load_active,
  output logic normal_seq_active_flag,
  output logic [8*`LSS_MEMO_CHARS-1:0] memo
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  lss_state_e state_ff, nxt_state;
  lss_cfg_s cfg_ff, nxt_cfg;
  logic [15:0] div_ff, nxt_div;
  logic [14:0] tmr_ff, nxt_tmr;
  logic [9:0] step_ff, nxt_step;
  logic [13:0] loop_ff, nxt_loop;
  logic [39:0] elapsed_ff, nxt_elapsed;
  logic [39:0] total_ff, nxt_total;
  logic no_seq_ff, nxt_no_seq;
  logic complete_ff, nxt_complete;
  logic rejected_ff, nxt_rejected;
  logic [8*`LSS_MEMO_CHARS-1:0] memo_ff, nxt_memo;
  lss_stat_s stat_ff, nxt_stat;
  logic normal_seq_active_flag_ff, nxt_normal_seq_active_flag;
  logic [15:0] rd_data;
  logic tick;
  logic [10:0] last_c;
  logic [13:0] loops_c;
  logic [14:0] tb_c;
  logic [39:0] remain_c;
  logic fast_ok;
  logic last_step_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Step store

  lss_step_mem #(
    .DEPTH(DEPTH),
    .AW(10),
    .DW(16)
  ) u_mem (
    .ref_clk(ref_clk),
    .wr_en(step_wr_en),
    .wr_addr(step_wr_addr),
    .wr_data(step_wr_data),
    .rd_addr(nxt_step),
    .rd_data(rd_data)
  ); // RULE10

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    nxt_state = state_ff;
    nxt_cfg = cfg_ff;
    nxt_div = div_ff;
    nxt_tmr = tmr_ff;
    nxt_step = step_ff;
    nxt_loop = loop_ff;
    nxt_elapsed = elapsed_ff;
    nxt_total = total_ff;
    nxt_no_seq = no_seq_ff;
    nxt_complete = complete_ff;
    nxt_rejected = rejected_ff;
    nxt_memo = memo_ff;
    nxt_normal_seq_active_flag = seq_enable & ~cfg.fast;
    tick = 1'b0;
    remain_c = 40'h0000000000;

    if (memo_wr_en && (memo_wr_idx < 4'(`LSS_MEMO_CHARS))) begin
      nxt_memo[8*memo_wr_idx +: 8] = memo_wr_char; // RULE14
    end

    // Start-time clamps keep odd panel values inside the documented ranges
    last_c = cfg.loop_end_step;
    if (last_c == 11'h000) begin
      last_c = 11'h001;
    end
    if (last_c > step_count) begin
      last_c = step_count;
    end
    if (last_c > 11'(DEPTH)) begin
      last_c = 11'(DEPTH);
    end // RULE17
    loops_c = cfg.loops;
    if (loops_c == 14'h0000) begin
      loops_c = 14'h0001;
    end
    if (loops_c > 14'(`LSS_MAX_LOOPS)) begin
      loops_c = 14'(`LSS_MAX_LOOPS);
    end // RULE11
    tb_c = cfg.time_base;
    if (tb_c < 15'(`LSS_TB_MIN)) begin
      tb_c = 15'(`LSS_TB_MIN);
    end
    if (tb_c > 15'(`LSS_TB_MAX)) begin
      tb_c = 15'(`LSS_TB_MAX);
    end // RULE16
    fast_ok = ((cfg.mode == const_current_mode) || (cfg.mode == const_resistance_mode)) // RULE9
      && ((cfg.range == low_i_low_v_range) || (cfg.range == mid_i_low_v_range)
      || (cfg.range == high_i_low_v_range)) // RULE15
      && (step_count >= 11'(`LSS_MIN_FAST_STEPS)); // RULE18
    last_step_hit = (11'(step_ff) + 11'h001) >= {1'b0, cfg_ff.loop_end_step[9:0]}
      || step_ff == 10'(DEPTH - 1);

    // Divider only runs in RUN, so a pause freezes the partial tick too
    if (state_ff == LSS_RUN) begin
      if (32'(div_ff) >= TICK_CYC - 1) begin
        nxt_div = 16'h0000;
        tick = 1'b1;
      end else begin
        nxt_div = div_ff + 16'h0001;
      end
    end // RULE20

    case (state_ff)
      LSS_IDLE, LSS_HOLD: begin
        if (load_off_cmd) begin
          nxt_state = LSS_IDLE;
        end else if (load_on_cmd && seq_enable) begin
          nxt_no_seq = 1'b0;
          nxt_complete = 1'b0;
          nxt_rejected = 1'b0;
          if (step_count == 11'h000) begin
            nxt_no_seq = 1'b1; // RULE4
            nxt_state = LSS_IDLE;
          end else if (cfg.fast && !fast_ok) begin
            nxt_rejected = 1'b1; // RULE9
            nxt_state = LSS_IDLE;
          end else begin
            nxt_cfg = cfg;
            nxt_cfg.loop_end_step = last_c;
            nxt_cfg.loops = loops_c;
            nxt_cfg.time_base = tb_c;
            nxt_step = 10'h000;
            nxt_loop = 14'h0000;
            nxt_tmr = tb_c;
            nxt_div = 16'h0000;
            nxt_elapsed = 40'h0000000000;
            nxt_total = cfg.loop_inf ? 40'h0000000000 : 40'(tb_c) * 40'(last_c) * 40'(loops_c);
            nxt_state = LSS_RUN; // RULE1
          end
        end
      end
      LSS_RUN: begin
        if (load_off_cmd) begin
          nxt_state = LSS_IDLE; // RULE2
        end else if (pause_cmd) begin
          // Keep the partial tick, so a pause on a tick edge never swallows it
          nxt_div = div_ff; // RULE20
          nxt_state = LSS_PAUSED; // RULE3
        end else if (tick) begin
          nxt_elapsed = elapsed_ff + 40'h0000000001;
          if (tmr_ff <= 15'h0001) begin
            nxt_tmr = cfg_ff.time_base; // RULE19
            if (!last_step_hit) begin
              nxt_step = step_ff + 10'h001; // RULE8
            end else if (!cfg_ff.loop_inf && (loop_ff + 14'h0001 >= cfg_ff.loops)) begin
              nxt_complete = 1'b1; // RULE5
              nxt_state = cfg_ff.end_hold ? LSS_HOLD : LSS_IDLE; // RULE12
            end else begin
              nxt_step = 10'h000; // RULE17
              if (loop_ff < 14'(`LSS_MAX_LOOPS - 1)) begin
                nxt_loop = loop_ff + 14'h0001; // RULE11
              end
            end
          end else begin
            nxt_tmr = tmr_ff - 15'h0001;
          end
        end
      end
      LSS_PAUSED: begin
        if (load_off_cmd) begin
          nxt_state = LSS_IDLE; // RULE2
        end else if (continue_cmd) begin
          nxt_state = LSS_RUN; // RULE3
        end
      end
      default: begin
        nxt_state = LSS_IDLE;
      end
    endcase

    if (nxt_total > nxt_elapsed) begin
      remain_c = nxt_total - nxt_elapsed;
    end
    nxt_stat.seq_index = nxt_cfg.seq_index;
    nxt_stat.step_index = 11'(nxt_step) + 11'h001;
    nxt_stat.loop_count = nxt_loop + 14'h0001;
    nxt_stat.step_time = nxt_tmr;
    nxt_stat.run_time_is_elapsed = (nxt_elapsed > THRESH_TICKS) || nxt_cfg.loop_inf;
    nxt_stat.run_time = nxt_stat.run_time_is_elapsed ? nxt_elapsed : remain_c; // RULE7
    nxt_stat.running = (nxt_state == LSS_RUN);
    nxt_stat.paused = (nxt_state == LSS_PAUSED);
    nxt_stat.no_seq = nxt_no_seq;
    nxt_stat.complete = nxt_complete;
    nxt_stat.rejected = nxt_rejected; // RULE6
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= LSS_IDLE;
      cfg_ff <= '0;
      div_ff <= 16'h0000;
      tmr_ff <= 15'h0000;
      step_ff <= 10'h000;
      loop_ff <= 14'h0000;
      elapsed_ff <= 40'h0000000000;
      total_ff <= 40'h0000000000;
      no_seq_ff <= 1'b0;
      complete_ff <= 1'b0;
      rejected_ff <= 1'b0;
      memo_ff <= '0;
      stat_ff <= '0;
      normal_seq_active_flag_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cfg_ff <= nxt_cfg;
      div_ff <= nxt_div;
      tmr_ff <= nxt_tmr;
      step_ff <= nxt_step;
      loop_ff <= nxt_loop;
      elapsed_ff <= nxt_elapsed;
      total_ff <= nxt_total;
      no_seq_ff <= nxt_no_seq;
      complete_ff <= nxt_complete;
      rejected_ff <= nxt_rejected;
      memo_ff <= nxt_memo;
      stat_ff <= nxt_stat;
      normal_seq_active_flag_ff <= nxt_normal_seq_active_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Straight mux of stored values: a step change lands in one edge, no slope
  always_comb begin
    case (state_ff)
      LSS_RUN, LSS_PAUSED: setpoint = rd_data; // RULE13
      LSS_HOLD: setpoint = cfg_ff.hold_level; // RULE12
      default: setpoint = `LSS_SETPOINT_RST;
    endcase
  end

  assign load_active = (state_ff != LSS_IDLE);
  assign stat = stat_ff;
  assign memo = memo_ff;
  assign normal_seq_active_flag = normal_seq_active_flag_ff;

endmodule : lss_sequencer

`default_nettype wire

// [lss_sequencer_asserts.sv]
/* Port checker of the load step sequencer.
   Assumes it is bound into lss_sequencer and sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module lss_sequencer_asserts import lss_pkg::*; #(
  parameter int unsigned TICK_CYC = 500,
  parameter logic [39:0] THRESH_TICKS = 40'h1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic seq_enable,
  input wire logic load_on_cmd,
  input wire logic load_off_cmd,
  input wire logic pause_cmd,
  input wire logic continue_cmd,
  input wire lss_cfg_s cfg,
  input wire logic [10:0] step_count,
  input wire lss_stat_s stat,
  input wire logic [15:0] setpoint,
  input wire logic load_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Load-off outranks every other command, so it is left out of go
  wire logic go = load_on_cmd && seq_enable && !load_off_cmd;
  sequence s_live;
    stat.running && !load_off_cmd && !pause_cmd && !load_on_cmd;
  endsequence
  sequence s_run_end;
    s_live ##1 !stat.running && !stat.paused;
  endsequence
  a_start_now: assert property (
    go && step_count != 11'h000 && !cfg.fast |=> load_active && stat.running
    && stat.step_index == 11'h001 && stat.loop_count == 14'h0001) else $error("run did not start");
  a_off_stops: assert property (
    load_off_cmd && stat.running |=> !load_active && !stat.running) else $error("load off ignored");
  a_pause_freeze: assert property (
    stat.paused && !continue_cmd && !load_off_cmd && !load_on_cmd |=> $stable(stat.step_time)
    && $stable(stat.run_time) && $stable(stat.step_index)) else $error("paused run moved");
  a_empty_refused: assert property (
    go && step_count == 11'h000 |=> stat.no_seq && !load_active) else $error("empty run accepted");
  a_end_flag: assert property (
    s_run_end |-> stat.complete) else $error("end without complete");
  a_fast_mode: assert property (
    go && cfg.fast && step_count != 11'h000 && (cfg.mode inside {const_voltage_mode, const_power_mode}
    || step_count < 11'h003) |=> stat.rejected && !load_active) else $error("bad fast run accepted");
  a_step_reload: assert property (
    stat.running && $changed(stat.step_index) |-> stat.step_time == cfg.time_base)
    else $error("step time not reloaded");
  a_hold_level: assert property (
    load_active && !stat.running && !stat.paused |-> setpoint == cfg.hold_level) else $error("hold level lost");
  a_step_bound: assert property (
    stat.running |-> stat.step_index >= 11'h001 && stat.step_index <= cfg.loop_end_step)
    else $error("step past loop end");
endmodule : lss_sequencer_asserts
`default_nettype wire

// [lss_panel_model.sv]
/* Front panel model: turns a bench request into one command pulse.
   Assumes each request is held for one ref_clk cycle. */
`timescale 1ns/10ps
`default_nettype none
module lss_panel_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [1:0] code,
  output logic [3:0] cmd_ff
);
  // Registered so every pulse leaves right after an edge, one cycle wide
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff <= 4'h0;
    end else begin
      cmd_ff <= go ? (4'h1 << code) : 4'h0;
    end
  end
endmodule : lss_panel_model
`default_nettype wire

// [lss_sequencer_tb_top.sv]
/* Self-checking bench of the load step sequencer with random setpoints.
   Assumes lss_pkg, the panel model and the checker are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
`include "lss_regs.svh"
module lss_sequencer_tb_top import lss_pkg::*; ();
  logic ref_clk = 0, rst_n = 0, seq_enable = 0, step_wr_en = 0, memo_wr_en = 0, go = 0;
  logic [1:0] code = 0;
  lss_cfg_s cfg = '0;
  logic [10:0] step_count = 0;
  logic [9:0] step_wr_addr = 0;
  logic [15:0] step_wr_data = 0, hl;
  logic [3:0] memo_wr_idx = 0;
  logic [7:0] memo_wr_char = 0;
  wire logic [3:0] cmd_ff;
  lss_stat_s stat;
  logic [15:0] setpoint, sp [0:2];
  logic load_active, nsa;
  logic [95:0] memo, mx;
  logic [14:0] t;
  int failures = 0, checks = 0, cyc = 0;
  always #25 ref_clk = ~ref_clk;
  lss_panel_model u_panel (.ref_clk, .rst_n, .go, .code, .cmd_ff);
  // Short tick keeps each step a few cycles long
  lss_sequencer #(.TICK_CYC(2), .THRESH_TICKS(40'h64)) dut (.ref_clk, .rst_n, .seq_enable,
    .load_on_cmd(cmd_ff[0]), .load_off_cmd(cmd_ff[1]), .pause_cmd(cmd_ff[2]), .continue_cmd(cmd_ff[3]),
    .cfg, .step_count, .step_wr_en, .step_wr_addr, .step_wr_data, .memo_wr_en, .memo_wr_idx,
    .memo_wr_char, .stat, .setpoint, .load_active, .normal_seq_active_flag(nsa), .memo);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic cmd(input logic [1:0] c);
    @(posedge ref_clk);
    go <= 1'b1;
    code <= c;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : cmd
  task automatic start(input logic f, input int m, input int r, input logic [10:0] le,
      input logic [13:0] lp, input logic h, input logic inf);
    @(posedge ref_clk);
    cfg <= '{fast: f, mode: lss_mode_e'(m), range: lss_range_e'(r), loops: lp, loop_inf: inf,
      end_hold: h, hold_level: hl, loop_end_step: le, time_base: 15'h0002, seq_index: 4'h3};
    cmd(2'h0);
  endtask : start
  function automatic logic fast_ok(input int m, input int r, input logic [10:0] n);
    return n >= 11'h003 && m < 2 && r < 3;
  endfunction : fast_ok
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(77595));
    hl = 16'($urandom);
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      mx[8*(i%12)+:8] = (i < 12) ? 8'($urandom) : mx[7:0];
      if (i < 3) sp[i] = 16'($urandom);
      @(posedge ref_clk);
      {step_wr_en, memo_wr_en} <= {i < 3, 1'b1};
      {step_wr_addr, step_wr_data} <= {10'(i), sp[i%3]};
      {memo_wr_idx, memo_wr_char} <= {4'(i), i < 12 ? mx[8*i+:8] : 8'hA5};
    end
    @(posedge ref_clk);
    {step_wr_en, memo_wr_en} <= 2'h0;
    @(posedge ref_clk);
    #1 chk(memo, mx);
    $display("test memo done");
    seq_enable <= 1'b1;
    step_count <= 11'h003;
    start(0, 0, 0, 11'h003, 14'h0002, 0, 0);
    chk({stat.running, stat.step_index, stat.loop_count}, {1'b1, 11'h001, 14'h0001});
    chk({setpoint, nsa, stat.run_time_is_elapsed}, {sp[0], 2'b10});
    for (int k = 1; k < 6; k++) begin
      repeat (4) @(posedge ref_clk);
      #1 chk({stat.step_index, setpoint}, {11'(k % 3 + 1), sp[k%3]});
      chk(stat.loop_count, 14'(k / 3 + 1));
      chk({stat.step_time, stat.run_time}, {15'h0002, 40'(12 - 2 * k)});
    end
    repeat (4) @(posedge ref_clk);
    #1 chk({stat.complete, load_active}, 2'b10);
    $display("test normal run done");
    start(0, 1, 0, 11'h003, 14'h0002, 0, 0);
    repeat (5) @(posedge ref_clk);
    cmd(2'h2);
    t = stat.step_time;
    repeat (9) @(posedge ref_clk);
    #1 chk({stat.paused, stat.step_time}, {1'b1, t});
    cmd(2'h3);
    chk({stat.running, stat.step_time}, {1'b1, t});
    cmd(2'h1);
    chk({load_active, stat.running}, 2'b00);
    $display("test pause and stop done");
    step_count <= 11'h000;
    start(0, 0, 0, 11'h003, 14'h0001, 0, 0);
    chk({stat.no_seq, load_active}, 2'b10);
    $display("test empty done");
    for (int i = 0; i < 11; i++) begin
      step_count <= (i == 10) ? 11'h002 : 11'h003;
      start(1, i < 4 ? i : 0, i < 4 ? 0 : i - 4, 11'h003, 14'h0001, 0, 1);
      chk(load_active, fast_ok(i < 4 ? i : 0, i < 4 ? 0 : i - 4, i == 10 ? 2 : 3));
      if (load_active === 1'b1) chk(stat.run_time_is_elapsed, 1'b1);
      cmd(2'h1);
    end
    $display("test fast accept done");
    step_count <= 11'h003;
    start(1, 1, 1, 11'h003, 14'h0028, 1, 0);
    for (int n = 0; n < 600 && stat.complete !== 1'b1; n++) #50;
    #1 chk({load_active, setpoint, stat.complete}, {1'b1, hl, 1'b1});
    chk({stat.run_time_is_elapsed, stat.run_time}, {1'b1, 40'h00000000F0});
    cmd(2'h1);
    $display("test end hold done");
    tally_and_finish();
  end
endmodule : lss_sequencer_tb_top
bind lss_sequencer lss_sequencer_asserts #(.TICK_CYC(TICK_CYC), .THRESH_TICKS(THRESH_TICKS)) u_chk (
  .ref_clk, .rst_n, .seq_enable, .load_on_cmd, .load_off_cmd, .pause_cmd, .continue_cmd, .cfg,
  .step_count, .stat, .setpoint, .load_active);
`default_nettype wire
